/* File: hw/qdc_pkg.sv */
// Constants and types shared by the quad converter control block
`default_nettype none
package qdc_pkg;
    // APB register byte offsets
    localparam logic [7:0] QDC_OFF_CTRL = 8'h00;
    localparam logic [7:0] QDC_OFF_STATUS = 8'h04;
    localparam logic [7:0] QDC_OFF_ADDR = 8'h08;
    localparam logic [7:0] QDC_OFF_WORD = 8'h0C;
    localparam logic [7:0] QDC_OFF_DAC_BASE = 8'h10;
    localparam logic [7:0] QDC_OFF_IN_BASE = 8'h20;
    // Control register fields and reset values
    localparam int QDC_CTRL_SYNC_BIT = 0;
    localparam int QDC_CTRL_LOAD_BIT = 1;
    localparam logic QDC_CTRL_SYNC_RST = 1'b0;
    // Status register fields
    localparam int QDC_ST_INIT_BIT = 0;
    localparam int QDC_ST_SPAN_BIT = 1;
    localparam int QDC_ST_LEVEL_BIT = 2;
    localparam int QDC_ST_DEVRST_BIT = 3;
    localparam int QDC_ST_BUSY_BIT = 4;
    localparam int QDC_ST_PEND_LSB = 8;
    // Widths
    localparam int QDC_CODE_W = 16;
    localparam int QDC_WORD_W = 24;
    localparam int QDC_NCH = 4;
    // Preset codes
    localparam logic [15:0] QDC_ZERO_SCALE = 16'h0000;
    localparam logic [15:0] QDC_MID_SCALE = 16'h8000;
    // Fixed upper slave address bits, value arbitrary
    localparam logic [4:0] QDC_ADDR_UPPER = 5'h0C;
    // Serial word layout and commands
    localparam int QDC_CMD_LSB = 20;
    localparam int QDC_CH_LSB = 16;
    localparam logic [3:0] QDC_CMD_WRITE_IN = 4'h1;
    localparam logic [3:0] QDC_CMD_UPDATE = 4'h2;
    localparam logic [3:0] QDC_CMD_WRITE_UPD = 4'h3;
    // Serial byte framing
    localparam logic [3:0] QDC_BYTE_BITS = 4'h8;
    localparam logic [1:0] QDC_LAST_BYTE = 2'h2;
    // State types
    typedef enum logic [1:0] {QDC_I2C_IDLE, QDC_I2C_ADDR, QDC_I2C_DATA, QDC_I2C_ACK} qdc_i2c_st_t;
    typedef enum logic {QDC_INIT_WAIT, QDC_RUN} qdc_run_st_t;
endpackage : qdc_pkg
`default_nettype wire

/* File: hw/qdc_chan_mem.sv */
// Input and converter registers of the four channels
`default_nettype none
module qdc_chan_mem (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Preset of all registers
    input wire logic preset_en,
    input wire logic [qdc_pkg::QDC_CODE_W-1:0] preset_val,
    // Serial write port
    input wire logic wr_en,
    input wire logic wr_both,
    input wire logic [1:0] wr_idx,
    input wire logic [qdc_pkg::QDC_CODE_W-1:0] wr_data,
    // Transfer of input to converter registers
    input wire logic [qdc_pkg::QDC_NCH-1:0] copy_mask,
    // Registered read port
    input wire logic [2:0] rd_idx,
    output logic [qdc_pkg::QDC_CODE_W-1:0] rd_data,
    // Parallel views
    output logic [qdc_pkg::QDC_NCH-1:0][qdc_pkg::QDC_CODE_W-1:0] in_codes,
    output logic [qdc_pkg::QDC_NCH-1:0][qdc_pkg::QDC_CODE_W-1:0] dac_codes
);
    import qdc_pkg::*;

    // Input registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_codes <= '0;
        end else if (preset_en) begin
            in_codes <= {QDC_NCH{preset_val}};
        end else if (wr_en) begin
            in_codes[wr_idx] <= wr_data;
        end
    end

    // Converter registers; a direct write beats a transfer of the old value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_codes <= '0;
        end else if (preset_en) begin
            dac_codes <= {QDC_NCH{preset_val}};
        end else begin
            for (int i = 0; i < QDC_NCH; i++) begin
                if (wr_en && wr_both && wr_idx == 2'(i)) begin
                    dac_codes[i] <= wr_data;
                end else if (copy_mask[i]) begin
                    dac_codes[i] <= in_codes[i];
                end
            end
        end
    end

    // Read port, one cycle behind the index
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= '0;
        end else begin
            rd_data <= rd_idx[2] ? in_codes[rd_idx[1:0]] : dac_codes[rd_idx[1:0]];
        end
    end
endmodule : qdc_chan_mem
`default_nettype wire

/* File: hw/qdc_i2c_rx.sv */
// Two-wire serial write receiver with address match and acknowledge
`default_nettype none
module qdc_i2c_rx (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Own address
    input wire logic [6:0] slave_addr,
    // Received words
    output logic word_valid,
    output logic [qdc_pkg::QDC_WORD_W-1:0] word_data,
    output logic busy
);
    import qdc_pkg::*;

    qdc_i2c_st_t st_r;
    logic scl_q_r;
    logic sda_q_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [1:0] byte_idx_r;
    logic [15:0] part_r;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic byte_full;
    logic addr_ok;

    // Bus events from previous pin samples
    assign scl_rise = scl_in & ~scl_q_r;
    assign scl_fall = ~scl_in & scl_q_r;
    assign start_cond = scl_in & scl_q_r & sda_q_r & ~sda_in;
    assign stop_cond = scl_in & scl_q_r & ~sda_q_r & sda_in;
    assign byte_full = scl_fall && (bit_cnt_r == QDC_BYTE_BITS);
    assign addr_ok = (shift_r[7:1] == slave_addr) && !shift_r[0];
    assign sda_out = 1'b0; // Open drain: only ever pulls low
    assign busy = (st_r != QDC_I2C_IDLE);

    // Pin history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl_in;
            sda_q_r <= sda_in;
        end
    end

    // Receive state machine, bits taken on clock line rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= QDC_I2C_IDLE;
            bit_cnt_r <= '0;
            shift_r <= '0;
            byte_idx_r <= '0;
            part_r <= '0;
            sda_oe <= 1'b0;
        end else if (start_cond) begin
            st_r <= QDC_I2C_ADDR;
            bit_cnt_r <= '0;
            byte_idx_r <= '0;
            sda_oe <= 1'b0;
        end else if (stop_cond) begin
            st_r <= QDC_I2C_IDLE;
            sda_oe <= 1'b0;
        end else begin
            case (st_r)
                QDC_I2C_ADDR, QDC_I2C_DATA: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_in};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (byte_full) begin
                        if (st_r == QDC_I2C_DATA || addr_ok) begin
                            st_r <= QDC_I2C_ACK;
                            sda_oe <= 1'b1;
                        end else begin
                            st_r <= QDC_I2C_IDLE;
                        end
                        if (st_r == QDC_I2C_DATA) begin
                            part_r <= {part_r[7:0], shift_r};
                            byte_idx_r <= (byte_idx_r == QDC_LAST_BYTE) ? 2'h0 : byte_idx_r + 2'h1;
                        end
                    end
                end
                QDC_I2C_ACK: begin
                    if (scl_fall) begin
                        st_r <= QDC_I2C_DATA;
                        sda_oe <= 1'b0;
                        bit_cnt_r <= '0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Whole word pulse after the third data byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_valid <= 1'b0;
            word_data <= '0;
        end else begin
            word_valid <= byte_full && st_r == QDC_I2C_DATA && byte_idx_r == QDC_LAST_BYTE && !start_cond
                && !stop_cond;
            if (byte_full && st_r == QDC_I2C_DATA && byte_idx_r == QDC_LAST_BYTE) begin
                word_data <= {part_r, shift_r};
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Acknowledge starts just after a clock line fall
    property p_ack_on_fall;
        $rose(sda_oe) |-> ($past(scl_in, 2) && !$past(scl_in));
    endproperty
    a_ack_on_fall: assert property (p_ack_on_fall) else $error("ack not driven at scl fall");

    // Low address bits must match the pins
    property p_addr_low;
        (st_r == QDC_I2C_ADDR && byte_full && !start_cond && !stop_cond && shift_r[2:1] != slave_addr[1:0])
            |=> !sda_oe && st_r == QDC_I2C_IDLE;
    endproperty
    a_addr_low: assert property (p_addr_low) else $error("acked wrong low address bits");

    // Upper address bits must match the fixed value
    property p_addr_upper;
        (st_r == QDC_I2C_ADDR && byte_full && !start_cond && !stop_cond && shift_r[7:3] != QDC_ADDR_UPPER)
            |=> !sda_oe;
    endproperty
    a_addr_upper: assert property (p_addr_upper) else $error("acked wrong upper address bits");
endmodule : qdc_i2c_rx
`default_nettype wire

/* File: hw/qdc_ctrl.sv */
// Pin control of a quad converter: serial receiver, load strobe, reset and APB view
//
// Overview of operation
// - Pin addr_pin_low sets address bit 0, addr_pin_high sets bit 1.
// - Data moves via 24-bit shift register on serial clock; data line open-drain.
// - Strobe falling edge copies every pending input register to its converter register together.
// - Asynchronous and synchronous strobe modes; strobe tied low is valid.
// - Device reset low loads input and converter registers with zero or midscale.
// - While device reset is low, strobe pulses are ignored, no transfer happens.
// - Device reset low at power-up delays initialization until it is released.
// - Power-up starts all channels at zero or midscale by reset_level_select.
// - Gain pin selects span of one or two times the reference.
// - Channel codes are straight binary.
//
// The APB slave port and the address map were decided locally.
`default_nettype none
module qdc_ctrl (
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Two-wire serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Control pins
    input wire logic addr_pin_low,
    input wire logic addr_pin_high,
    input wire logic load_strobe_n,
    input wire logic dev_reset_n,
    input wire logic reset_level_select,
    input wire logic gain_pin,
    // Converter side
    output logic [qdc_pkg::QDC_CODE_W-1:0] dac_code_a,
    output logic [qdc_pkg::QDC_CODE_W-1:0] dac_code_b,
    output logic [qdc_pkg::QDC_CODE_W-1:0] dac_code_c,
    output logic [qdc_pkg::QDC_CODE_W-1:0] dac_code_d,
    output logic span_x2,
    output logic init_done
);
    import qdc_pkg::*;

    qdc_run_st_t run_st_r;
    logic sync_mode_r;
    logic soft_load_r;
    logic strobe_q_r;
    logic span_r;
    logic [QDC_NCH-1:0] pending_r;
    logic [QDC_WORD_W-1:0] last_word_r;
    logic [6:0] slave_addr;
    logic word_valid;
    logic [QDC_WORD_W-1:0] word_data;
    logic i2c_busy;
    logic [3:0] cmd;
    logic [QDC_CODE_W-1:0] rst_val;
    logic preset_en;
    logic wr_en;
    logic wr_both;
    logic [1:0] wr_idx;
    logic [QDC_CODE_W-1:0] wr_data;
    logic [QDC_NCH-1:0] copy_mask;
    logic [QDC_NCH-1:0] set_mask;
    logic [QDC_NCH-1:0] clr_mask;
    logic [QDC_NCH-1:0][QDC_CODE_W-1:0] in_codes;
    logic [QDC_NCH-1:0][QDC_CODE_W-1:0] dac_codes;
    logic [2:0] rd_idx;
    logic [QDC_CODE_W-1:0] mem_rdata;
    logic strobe_fall;
    logic dev_live;
    logic ack_r;
    logic err_r;
    logic [31:0] rdata_r;
    logic [31:0] status_w;
    logic apb_wr;
    logic apb_first;

    // One-hot channel select
    function automatic logic [QDC_NCH-1:0] qdc_onehot(input logic [1:0] idx);
        qdc_onehot = 4'h1 << idx;
    endfunction : qdc_onehot

    // Aligned word inside a 16-byte channel window
    function automatic logic qdc_in_window(input logic [7:0] addr, input logic [7:0] base);
        qdc_in_window = (addr[7:4] == base[7:4]) && (addr[1:0] == 2'h0);
    endfunction : qdc_in_window

    // Own address from fixed bits and pins
    assign slave_addr = {QDC_ADDR_UPPER, addr_pin_high, addr_pin_low};

    // Serial receiver
    qdc_i2c_rx u_rx (
        .pclk(pclk),
        .presetn(presetn),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .slave_addr(slave_addr),
        .word_valid(word_valid),
        .word_data(word_data),
        .busy(i2c_busy)
    );

    // Channel register storage
    qdc_chan_mem u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .preset_en(preset_en),
        .preset_val(rst_val),
        .wr_en(wr_en),
        .wr_both(wr_both),
        .wr_idx(wr_idx),
        .wr_data(wr_data),
        .copy_mask(copy_mask),
        .rd_idx(rd_idx),
        .rd_data(mem_rdata),
        .in_codes(in_codes),
        .dac_codes(dac_codes)
    );

    // Codes leave as straight binary, no recoding
    assign dac_code_a = dac_codes[0];
    assign dac_code_b = dac_codes[1];
    assign dac_code_c = dac_codes[2];
    assign dac_code_d = dac_codes[3];

    // Span follows the gain pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            span_r <= 1'b0;
        end else begin
            span_r <= gain_pin;
        end
    end
    assign span_x2 = span_r;

    // Strobe history for falling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_q_r <= 1'b1;
        end else begin
            strobe_q_r <= load_strobe_n;
        end
    end
    assign strobe_fall = strobe_q_r & ~load_strobe_n;

    // Power-up waits for device reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_st_r <= QDC_INIT_WAIT;
        end else begin
            case (run_st_r)
                QDC_INIT_WAIT: begin
                    if (dev_reset_n) begin
                        run_st_r <= QDC_RUN;
                    end
                end
                default: begin
                end
            endcase
        end
    end
    assign init_done = (run_st_r == QDC_RUN);
    assign dev_live = dev_reset_n && (run_st_r == QDC_RUN);

    // Preset level and when it is loaded
    assign rst_val = reset_level_select ? QDC_MID_SCALE : QDC_ZERO_SCALE;
    assign preset_en = dev_reset_n ? (run_st_r == QDC_INIT_WAIT) : (run_st_r == QDC_RUN);

    // Command decode and strobe transfer
    always_comb begin
        cmd = word_data[QDC_CMD_LSB +: 4];
        wr_idx = word_data[QDC_CH_LSB +: 2];
        wr_data = word_data[QDC_CODE_W-1:0];
        wr_en = 1'b0;
        wr_both = 1'b0;
        set_mask = '0;
        copy_mask = '0;
        if (dev_live) begin
            if (word_valid) begin
                if (cmd == QDC_CMD_WRITE_IN) begin
                    wr_en = 1'b1;
                    if (!sync_mode_r && !load_strobe_n) begin
                        wr_both = 1'b1;
                    end else begin
                        set_mask = qdc_onehot(wr_idx);
                    end
                end else if (cmd == QDC_CMD_WRITE_UPD) begin
                    wr_en = 1'b1;
                    wr_both = 1'b1;
                end else if (cmd == QDC_CMD_UPDATE) begin
                    copy_mask = qdc_onehot(wr_idx);
                end
            end
            if (strobe_fall || soft_load_r) begin
                copy_mask = copy_mask | pending_r;
            end
        end
    end
    assign clr_mask = copy_mask | (wr_both ? qdc_onehot(wr_idx) : 4'h0);

    // New-data flags; a new write beats a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_r <= '0;
        end else if (preset_en) begin
            pending_r <= '0;
        end else begin
            pending_r <= (pending_r & ~clr_mask) | set_mask;
        end
    end

    // Last received word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_word_r <= '0;
        end else if (word_valid) begin
            last_word_r <= word_data;
        end
    end

    // APB handshake: one wait state on every access
    assign apb_first = psel && penable && !ack_r;
    assign apb_wr = psel && penable && ack_r && pwrite;
    assign pready = ack_r;
    assign prdata = rdata_r;
    assign pslverr = ack_r & err_r;
    assign rd_idx = {paddr[5], paddr[3:2]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= apb_first;
        end
    end

    // Control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_mode_r <= QDC_CTRL_SYNC_RST;
            soft_load_r <= 1'b0;
        end else begin
            soft_load_r <= apb_wr && paddr == QDC_OFF_CTRL && pwdata[QDC_CTRL_LOAD_BIT];
            if (apb_wr && paddr == QDC_OFF_CTRL) begin
                sync_mode_r <= pwdata[QDC_CTRL_SYNC_BIT];
            end
        end
    end

    // Status word
    always_comb begin
        status_w = '0;
        status_w[QDC_ST_INIT_BIT] = init_done;
        status_w[QDC_ST_SPAN_BIT] = span_r;
        status_w[QDC_ST_LEVEL_BIT] = reset_level_select;
        status_w[QDC_ST_DEVRST_BIT] = !dev_reset_n;
        status_w[QDC_ST_BUSY_BIT] = i2c_busy;
        status_w[QDC_ST_PEND_LSB +: QDC_NCH] = pending_r;
    end

    // Read data and error, captured in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= '0;
            err_r <= 1'b0;
        end else if (apb_first) begin
            err_r <= 1'b0;
            rdata_r <= '0;
            if (paddr == QDC_OFF_CTRL) begin
                rdata_r[QDC_CTRL_SYNC_BIT] <= sync_mode_r;
            end else if (paddr == QDC_OFF_STATUS) begin
                rdata_r <= status_w;
            end else if (paddr == QDC_OFF_ADDR) begin
                rdata_r <= {25'h0, slave_addr};
            end else if (paddr == QDC_OFF_WORD) begin
                rdata_r <= {8'h0, last_word_r};
            end else if (qdc_in_window(paddr, QDC_OFF_DAC_BASE) || qdc_in_window(paddr, QDC_OFF_IN_BASE)) begin
                rdata_r <= {16'h0, mem_rdata};
            end else begin
                err_r <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Strobe edge with new data moves it to the output
    sequence s_pend_strobe;
        dev_live && pending_r[0] && strobe_fall && !word_valid;
    endsequence
    property p_strobe_copy;
        s_pend_strobe |=> (dac_code_a == $past(in_codes[0])) && !pending_r[0];
    endproperty
    a_strobe_copy: assert property (p_strobe_copy) else $error("strobe did not transfer channel a");

    // Asynchronous mode with strobe low writes straight through
    property p_async_direct;
        (dev_live && word_valid && cmd == QDC_CMD_WRITE_IN && !sync_mode_r && !load_strobe_n && wr_idx == 2'h1)
            |=> dac_code_b == $past(wr_data);
    endproperty
    a_async_direct: assert property (p_async_direct) else $error("direct write missed channel b");

    // Device reset loads both register sets
    property p_reset_load;
        (!dev_reset_n && run_st_r == QDC_RUN) |=> (dac_code_c == $past(rst_val)) && (in_codes[2] == $past(rst_val));
    endproperty
    a_reset_load: assert property (p_reset_load) else $error("device reset did not preset");

    // Held reset freezes outputs whatever the strobe does
    sequence s_held_low;
        (!dev_reset_n && $stable(reset_level_select)) [*2];
    endsequence
    property p_reset_ignores_strobe;
        s_held_low |=> $stable(dac_codes) && pending_r == 4'h0;
    endproperty
    a_reset_ignores_strobe: assert property (p_reset_ignores_strobe) else $error("transfer during reset");

    // No initialization while reset held at power-up
    property p_init_wait;
        (run_st_r == QDC_INIT_WAIT && !dev_reset_n) |=> !init_done && $stable(dac_codes);
    endproperty
    a_init_wait: assert property (p_init_wait) else $error("initialized under reset");

    // Power-up level follows the select pin
    property p_powerup_level;
        $rose(init_done) |-> (dac_code_a == $past(rst_val)) && (dac_code_d == $past(rst_val));
    endproperty
    a_powerup_level: assert property (p_powerup_level) else $error("wrong power-up level");

    // Span tracks the gain pin within a cycle
    property p_span;
        $changed(gain_pin) |=> span_x2 == $past(gain_pin) ##1 span_x2 == $past(gain_pin);
    endproperty
    a_span: assert property (p_span) else $error("span does not follow gain pin");

    // Synchronous mode holds outputs while strobe idles high
    property p_sync_hold;
        (dev_live && sync_mode_r && load_strobe_n && !soft_load_r
            && !(word_valid && (cmd == QDC_CMD_WRITE_UPD || cmd == QDC_CMD_UPDATE))) |=> $stable(dac_codes);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("output changed without update");
endmodule : qdc_ctrl
`default_nettype wire

/* File: sim/qdc_i2c_master.sv */
// Two-wire bus master model that writes whole words
`default_nettype none
module qdc_i2c_master (
    // Clock
    input wire logic pclk,
    // Bus lines
    input wire logic sda,
    output var logic scl = 1'b1,
    output var logic sda_low = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // One bit: data moves while clock is low, sampled mid high phase
    task automatic bit_io(input logic b, output logic s);
        sda_low <= !b;
        repeat (3) @(posedge pclk);
        scl <= 1'b1;
        repeat (3) @(posedge pclk);
        s = sda;
        repeat (2) @(posedge pclk);
        scl <= 1'b0;
    endtask : bit_io
    // Start, address, three data bytes, stop; clock idles high
    task automatic send(input logic [6:0] a, input logic [23:0] w, output logic ack);
        logic [35:0] v;
        logic s;
        v = {a, 2'b01, w[23:16], 1'b1, w[15:8], 1'b1, w[7:0], 1'b1};
        ack = 1'b0;
        sda_low <= 1'b1;
        repeat (4) @(posedge pclk);
        scl <= 1'b0;
        for (int i = 35; i >= 0; i--) begin
            bit_io(v[i], s);
            if (i == 27) ack = !s;
        end
        sda_low <= 1'b1;
        repeat (3) @(posedge pclk);
        scl <= 1'b1;
        repeat (3) @(posedge pclk);
        sda_low <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask : send
endmodule : qdc_i2c_master
`default_nettype wire

/* File: sim/test_quad_dac_pin_control.sv */
// Bench for the quad converter pin control
`default_nettype none
module test_quad_dac_pin_control;
    import qdc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, sda_out, sda_oe, span_x2, init_done, scl, sda_low, ack, err;
    logic a_lo = 0, a_hi = 1, ldn = 1, drn = 0, rsel = 1, gain = 0;
    logic [15:0] dc [4];
    logic [15:0] m_dac [4];
    logic [15:0] m_in [4];
    integer seed = 32'h12d43796, mismatches = 0, n_compared = 0;
    // Open-drain data line with pull-up
    wire sda = !(sda_low | (sda_oe & !sda_out));
    always #10 pclk = ~pclk;
    qdc_ctrl u_qdc_ctrl (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata,
        .pslverr, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .addr_pin_low(a_lo), .addr_pin_high(a_hi),
        .load_strobe_n(ldn), .dev_reset_n(drn), .reset_level_select(rsel), .gain_pin(gain),
        .dac_code_a(dc[0]), .dac_code_b(dc[1]), .dac_code_c(dc[2]), .dac_code_d(dc[3]), .span_x2, .init_done);
    qdc_i2c_master u_qdc_i2c_master (.pclk, .sda, .scl, .sda_low);
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_compared++;
        if (s !== x) begin
            mismatches++;
            $display("Error t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask : chk
    task automatic all_chk;
        for (int i = 0; i < 4; i++) chk(dc[i], m_dac[i]);
    endtask : all_chk
    // APB transfer, bounded wait for ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            end_sim();
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [3:0] cmd, input int ch, input logic [15:0] c);
        u_qdc_i2c_master.send({QDC_ADDR_UPPER, a_hi, a_lo}, {cmd, 2'b00, 2'(ch), c}, ack);
        chk(ack, 1);
    endtask : wr
    initial begin
        a_lo <= 1'($random(seed));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(init_done, 0);
        drn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(init_done, 1);
        foreach (m_dac[i]) m_dac[i] = QDC_MID_SCALE;
        all_chk();
        $display("test power-up done");
        for (int i = 0; i < 4; i++) begin
            m_dac[i] = 16'($random(seed));
            wr(QDC_CMD_WRITE_UPD, i, m_dac[i]);
        end
        m_in = m_dac;
        all_chk();
        u_qdc_i2c_master.send({QDC_ADDR_UPPER, a_hi, !a_lo}, 24'h30FFFF, ack);
        chk(ack, 0);
        u_qdc_i2c_master.send({~QDC_ADDR_UPPER, a_hi, a_lo}, 24'h30FFFF, ack);
        chk(ack, 0);
        all_chk();
        $display("test serial writes done");
        apb(1, QDC_OFF_CTRL, 1, rd);
        for (int i = 0; i < 4; i += 2) begin
            m_in[i] = 16'($random(seed));
            wr(QDC_CMD_WRITE_IN, i, m_in[i]);
        end
        all_chk();
        ldn <= 1'b0;
        repeat (2) @(posedge pclk);
        ldn <= 1'b1;
        repeat (3) @(posedge pclk);
        m_dac = m_in;
        all_chk();
        m_in[3] = 16'($random(seed));
        wr(QDC_CMD_WRITE_IN, 3, m_in[3]);
        wr(QDC_CMD_UPDATE, 3, 16'h0000);
        m_dac[3] = m_in[3];
        all_chk();
        m_in[1] = 16'($random(seed));
        wr(QDC_CMD_WRITE_IN, 1, m_in[1]);
        apb(1, QDC_OFF_CTRL, 3, rd);
        repeat (2) @(posedge pclk);
        m_dac[1] = m_in[1];
        all_chk();
        apb(1, QDC_OFF_CTRL, 0, rd);
        ldn <= 1'b0;
        m_in[1] = 16'($random(seed));
        wr(QDC_CMD_WRITE_IN, 1, m_in[1]);
        m_dac = m_in;
        all_chk();
        ldn <= 1'b1;
        $display("test strobe done");
        wr(QDC_CMD_WRITE_IN, 3, 16'h1234);
        rsel <= 1'b0;
        drn <= 1'b0;
        repeat (3) @(posedge pclk);
        foreach (m_dac[i]) m_dac[i] = QDC_ZERO_SCALE;
        m_in = m_dac;
        all_chk();
        ldn <= 1'b0;
        repeat (2) @(posedge pclk);
        ldn <= 1'b1;
        drn <= 1'b1;
        repeat (3) @(posedge pclk);
        all_chk();
        apb(0, QDC_OFF_IN_BASE + 8'h0C, 0, rd);
        chk(rd[15:0], m_in[3]);
        gain <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(span_x2, 1);
        apb(0, QDC_OFF_STATUS, 0, rd);
        chk(rd[QDC_ST_SPAN_BIT], 1);
        apb(0, QDC_OFF_ADDR, 0, rd);
        chk(rd[6:0], {QDC_ADDR_UPPER, a_hi, a_lo});
        apb(0, 8'hFC, 0, rd);
        chk(err, 1);
        $display("test reset and pins done");
        end_sim();
    end
endmodule : test_quad_dac_pin_control
`default_nettype wire
